// ==== rtl/cidec_map.vh ====
// Opcode map, class codes and length kinds of the instruction decoder
// Overview of operation
// - Word/byte add, subtract, with carry; 2/4 bytes
// - Signed/unsigned register multiply, 2 bytes
// - Short and long divide, signed/unsigned, 2 bytes
// - Complement and negate word/byte register, 2 bytes
// - AND, OR, XOR word/byte, 2/4 bytes
// - Bit clear/set 2 bytes; bit pairs 4
// - Masked high/low byte modify, 4 bytes
// - Compare then step register by 1/2
// - Normalize count into register, 2 bytes
// - Shifts, rotates, arithmetic shift right, 2 bytes
// - Moves with sign/zero byte extension, 2/4
// - Bit-test relative jumps, optional bit update, 4
// - Conditional jumps/calls and far jump/call, 4
// - Context switch 4 bytes; push/pop 2
// - Software trap by number, 2 bytes
// - Near, far and interrupt returns, 2 bytes
// - Power-down decodes valid, performs nothing
// - Atomic/register prefixes 2; page/segment 2/4
// - All coprocessor operations are 4 bytes
`ifndef CIDEC_MAP_VH
`define CIDEC_MAP_VH
`define CIDEC_CLS_ARITH           4'h0
`define CIDEC_CLS_MULDIV          4'h1
`define CIDEC_CLS_LOGIC           4'h2
`define CIDEC_CLS_BIT             4'h3
`define CIDEC_CLS_SHIFT           4'h4
`define CIDEC_CLS_MOVE            4'h5
`define CIDEC_CLS_JUMP            4'h6
`define CIDEC_CLS_STACK           4'h7
`define CIDEC_CLS_RETURN          4'h8
`define CIDEC_CLS_SYSTEM          4'h9
`define CIDEC_CLS_PREFIX          4'hA
`define CIDEC_CLS_COPROC          4'hB
`define CIDEC_LEN_NONE            2'h0
`define CIDEC_LEN_4               2'h1
`define CIDEC_LEN_2               2'h2
`define CIDEC_LEN_VAR             2'h3
`define CIDEC_ADDSUB_FIRST        7'h00
`define CIDEC_ADDSUB_LAST         7'h07
`define CIDEC_MULTIPLY_FIRST      7'h08
`define CIDEC_MULTIPLY_LAST       7'h09
`define CIDEC_DIVIDE_FIRST        7'h0A
`define CIDEC_DIVIDE_LAST         7'h0D
`define CIDEC_CPLNEG_FIRST        7'h0E
`define CIDEC_CPLNEG_LAST         7'h11
`define CIDEC_LOGIC_FIRST         7'h12
`define CIDEC_LOGIC_LAST          7'h17
`define CIDEC_BITSC_FIRST         7'h18
`define CIDEC_BITSC_LAST          7'h19
`define CIDEC_BITPAIR_FIRST       7'h1A
`define CIDEC_BITPAIR_LAST        7'h1F
`define CIDEC_BITFIELD_FIRST      7'h20
`define CIDEC_BITFIELD_LAST       7'h21
`define CIDEC_COMPARE_FIRST       7'h22
`define CIDEC_COMPARE_LAST        7'h27
`define CIDEC_NORMALIZE_COUNT_OP  7'h28
`define CIDEC_SHIFT_FIRST         7'h29
`define CIDEC_SHIFT_LAST          7'h2D
`define CIDEC_MOVE_FIRST          7'h2E
`define CIDEC_MOVE_LAST           7'h31
`define CIDEC_BITJUMP_FIRST       7'h32
`define CIDEC_BITJUMP_LAST        7'h35
`define CIDEC_JUMP_FIRST          7'h36
`define CIDEC_JUMP_LAST           7'h3E
`define CIDEC_CONTEXT_SWITCH_OP   7'h3F
`define CIDEC_PUSHPOP_FIRST       7'h40
`define CIDEC_PUSHPOP_LAST        7'h41
`define CIDEC_TRAP_OP             7'h42
`define CIDEC_RETURN_FIRST        7'h43
`define CIDEC_RETURN_LAST         7'h46
`define CIDEC_POWER_DOWN_OP       7'h47
`define CIDEC_SYSCTL_FIRST        7'h48
`define CIDEC_SYSCTL_LAST         7'h4D
`define CIDEC_SHORTSYS_FIRST      7'h4E
`define CIDEC_SHORTSYS_LAST       7'h4F
`define CIDEC_NOP_OP              7'h4F
`define CIDEC_SHORTPFX_FIRST      7'h50
`define CIDEC_SHORTPFX_LAST       7'h51
`define CIDEC_LONGPFX_FIRST       7'h52
`define CIDEC_LONGPFX_LAST        7'h55
`define CIDEC_COPROC_FIRST        7'h56
`define CIDEC_COPROC_LAST         7'h66
`define CIDEC_COPROC_NOP_OP       7'h66
`endif

// ==== rtl/cidec_rom.v ====
// Registered lookup table: operation index to validity, length kind and class
`timescale 1ns/10ps
`include "cidec_map.vh"
module cidec_rom (
  input  wire       sys_clk_in,
  input  wire       rst_in,
  input  wire [6:0] addr_in,
  output reg  [6:0] data_out
);

  function rng;
    input [6:0] a;
    input [6:0] lo;
    input [6:0] hi;
    begin
      rng = (a >= lo) && (a <= hi);
    end
  endfunction

  // Entry is {valid, length kind, class}
  function [6:0] entry;
    input [6:0] a;
    begin
      entry = 7'h00;
      if (rng(a, `CIDEC_ADDSUB_FIRST, `CIDEC_ADDSUB_LAST))
        entry = {1'b1, `CIDEC_LEN_VAR, `CIDEC_CLS_ARITH};
      if (rng(a, `CIDEC_MULTIPLY_FIRST, `CIDEC_MULTIPLY_LAST))
        entry = {1'b1, `CIDEC_LEN_2, `CIDEC_CLS_MULDIV};
      if (rng(a, `CIDEC_DIVIDE_FIRST, `CIDEC_DIVIDE_LAST))
        entry = {1'b1, `CIDEC_LEN_2, `CIDEC_CLS_MULDIV};
      if (rng(a, `CIDEC_CPLNEG_FIRST, `CIDEC_CPLNEG_LAST))
        entry = {1'b1, `CIDEC_LEN_2, `CIDEC_CLS_ARITH};
      if (rng(a, `CIDEC_LOGIC_FIRST, `CIDEC_LOGIC_LAST))
        entry = {1'b1, `CIDEC_LEN_VAR, `CIDEC_CLS_LOGIC};
      if (rng(a, `CIDEC_BITSC_FIRST, `CIDEC_BITSC_LAST))
        entry = {1'b1, `CIDEC_LEN_2, `CIDEC_CLS_BIT};
      if (rng(a, `CIDEC_BITPAIR_FIRST, `CIDEC_BITPAIR_LAST))
        entry = {1'b1, `CIDEC_LEN_4, `CIDEC_CLS_BIT};
      if (rng(a, `CIDEC_BITFIELD_FIRST, `CIDEC_BITFIELD_LAST))
        entry = {1'b1, `CIDEC_LEN_4, `CIDEC_CLS_BIT};
      if (rng(a, `CIDEC_COMPARE_FIRST, `CIDEC_COMPARE_LAST))
        entry = {1'b1, `CIDEC_LEN_VAR, `CIDEC_CLS_ARITH};
      if (a == `CIDEC_NORMALIZE_COUNT_OP)
        entry = {1'b1, `CIDEC_LEN_2, `CIDEC_CLS_SHIFT};
      if (rng(a, `CIDEC_SHIFT_FIRST, `CIDEC_SHIFT_LAST))
        entry = {1'b1, `CIDEC_LEN_2, `CIDEC_CLS_SHIFT};
      if (rng(a, `CIDEC_MOVE_FIRST, `CIDEC_MOVE_LAST))
        entry = {1'b1, `CIDEC_LEN_VAR, `CIDEC_CLS_MOVE};
      if (rng(a, `CIDEC_BITJUMP_FIRST, `CIDEC_BITJUMP_LAST))
        entry = {1'b1, `CIDEC_LEN_4, `CIDEC_CLS_JUMP};
      if (rng(a, `CIDEC_JUMP_FIRST, `CIDEC_JUMP_LAST))
        entry = {1'b1, `CIDEC_LEN_4, `CIDEC_CLS_JUMP};
      if (a == `CIDEC_CONTEXT_SWITCH_OP)
        entry = {1'b1, `CIDEC_LEN_4, `CIDEC_CLS_STACK};
      if (rng(a, `CIDEC_PUSHPOP_FIRST, `CIDEC_PUSHPOP_LAST))
        entry = {1'b1, `CIDEC_LEN_2, `CIDEC_CLS_STACK};
      if (a == `CIDEC_TRAP_OP)
        entry = {1'b1, `CIDEC_LEN_2, `CIDEC_CLS_JUMP};
      if (rng(a, `CIDEC_RETURN_FIRST, `CIDEC_RETURN_LAST))
        entry = {1'b1, `CIDEC_LEN_2, `CIDEC_CLS_RETURN};
      if (a == `CIDEC_POWER_DOWN_OP)
        entry = {1'b1, `CIDEC_LEN_4, `CIDEC_CLS_SYSTEM};
      if (rng(a, `CIDEC_SYSCTL_FIRST, `CIDEC_SYSCTL_LAST))
        entry = {1'b1, `CIDEC_LEN_4, `CIDEC_CLS_SYSTEM};
      if (rng(a, `CIDEC_SHORTSYS_FIRST, `CIDEC_SHORTSYS_LAST))
        entry = {1'b1, `CIDEC_LEN_2, `CIDEC_CLS_SYSTEM};
      if (rng(a, `CIDEC_SHORTPFX_FIRST, `CIDEC_SHORTPFX_LAST))
        entry = {1'b1, `CIDEC_LEN_2, `CIDEC_CLS_PREFIX};
      if (rng(a, `CIDEC_LONGPFX_FIRST, `CIDEC_LONGPFX_LAST))
        entry = {1'b1, `CIDEC_LEN_VAR, `CIDEC_CLS_PREFIX};
      if (rng(a, `CIDEC_COPROC_FIRST, `CIDEC_COPROC_LAST))
        entry = {1'b1, `CIDEC_LEN_4, `CIDEC_CLS_COPROC};
    end
  endfunction

  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      data_out <= 7'h00;
    end else begin
      data_out <= entry(addr_in);
    end
  end

endmodule

// ==== rtl/cidec_opnd.v ====
// Operand byte store: places trailing code bytes by position
`timescale 1ns/10ps
module cidec_opnd #(
  parameter BYTES = 3
) (
  input  wire               sys_clk_in,
  input  wire               rst_in,
  input  wire               clear_in,
  input  wire               wr_in,
  input  wire [1:0]         idx_in,
  input  wire [7:0]         byte_in,
  output reg  [8*BYTES-1:0] opnd_out
);

  integer i;

  always @(posedge sys_clk_in) begin
    if (rst_in || clear_in) begin
      opnd_out <= {(8*BYTES){1'b0}};
    end else if (wr_in) begin
      for (i = 0; i < BYTES; i = i + 1) begin
        if (idx_in == i[1:0]) begin
          opnd_out[8*i +: 8] <= byte_in;
        end
      end
    end
  end

endmodule

// ==== rtl/cidec_top.v ====
// Instruction decoder: class, length, sub-function and operation attributes
`timescale 1ns/10ps
`include "cidec_map.vh"
module cidec_top (
  input  wire        sys_clk_in,
  input  wire        rst_in,
  input  wire [7:0]  code_byte_in,
  input  wire        code_valid_in,
  output wire        code_ready_out,
  input  wire        exec_ready_in,
  output wire        instr_valid_out,
  output reg  [6:0]  instr_op_out,
  output reg  [3:0]  instr_class_out,
  output reg  [3:0]  instr_fn_out,
  output reg         instr_len4_out,
  output wire [23:0] instr_operand_out,
  output reg         instr_illegal_out,
  output reg         instr_no_action_out,
  output reg         instr_byte_out,
  output reg         instr_carry_out,
  output reg         instr_sub_out,
  output reg         instr_signed_out,
  output reg         instr_long_out,
  output reg         instr_high_out,
  output reg  [1:0]  instr_step_out,
  output reg         instr_step_down_out,
  output reg         instr_cond_out,
  output reg         instr_bit_write_out,
  output reg         instr_bit_value_out,
  output reg         instr_far_out,
  output reg         instr_call_out,
  output reg         instr_push_out,
  output reg         instr_pop_out,
  output reg         instr_ext_reg_out,
  output reg         fetch_adv_out,
  output reg         fetch_len4_out
);

  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_LOOK = 2'h1;
  localparam [1:0] S_COLL = 2'h2;
  localparam [1:0] S_OUT  = 2'h3;

  reg  [1:0] state;
  reg  [6:0] op;
  reg        op_lsb;
  reg  [1:0] idx;
  reg  [1:0] last_idx;
  wire [6:0] rom_data;
  wire       rom_valid;
  wire [1:0] rom_kind;
  wire       take;
  wire       coll_wr;

  reg        next_len4;
  reg        next_ill;
  reg        next_noact;
  reg  [6:0] d;
  reg        next_byte;
  reg        next_carry;
  reg        next_sub;
  reg        next_signed;
  reg        next_long;
  reg        next_high;
  reg  [1:0] next_step;
  reg        next_down;
  reg        next_cond;
  reg        next_bwr;
  reg        next_bval;
  reg        next_far;
  reg        next_call;
  reg        next_push;
  reg        next_pop;
  reg        next_xreg;

  function rng;
    input [6:0] a;
    input [6:0] lo;
    input [6:0] hi;
    begin
      rng = (a >= lo) && (a <= hi);
    end
  endfunction

  assign rom_valid       = rom_data[6];
  assign rom_kind        = rom_data[5:4];
  assign code_ready_out  = (state == S_IDLE) || (state == S_COLL);
  assign take            = code_valid_in && code_ready_out;
  assign coll_wr         = take && (state == S_COLL);
  assign instr_valid_out = (state == S_OUT);

  cidec_rom u_rom (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .addr_in    (code_byte_in[7:1]),
    .data_out   (rom_data)
  );

  cidec_opnd #(.BYTES(3)) u_opnd (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .clear_in   (state == S_LOOK),
    .wr_in      (coll_wr),
    .idx_in     (idx),
    .byte_in    (code_byte_in),
    .opnd_out   (instr_operand_out)
  );

  // Length and legality from the lookup entry and the form bit
  always @* begin
    next_ill   = !rom_valid || ((rom_kind != `CIDEC_LEN_VAR) && op_lsb);
    next_len4  = !next_ill && ((rom_kind == `CIDEC_LEN_4) ||
                 ((rom_kind == `CIDEC_LEN_VAR) && op_lsb));
    next_noact = !next_ill && ((op == `CIDEC_POWER_DOWN_OP) ||
                 (op == `CIDEC_NOP_OP) || (op == `CIDEC_COPROC_NOP_OP));
  end

  // Operation attributes by group and position inside the group
  always @* begin
    d           = 7'h00;
    next_byte   = 1'b0;
    next_carry  = 1'b0;
    next_sub    = 1'b0;
    next_signed = 1'b0;
    next_long   = 1'b0;
    next_high   = 1'b0;
    next_step   = 2'h0;
    next_down   = 1'b0;
    next_cond   = 1'b0;
    next_bwr    = 1'b0;
    next_bval   = 1'b0;
    next_far    = 1'b0;
    next_call   = 1'b0;
    next_push   = 1'b0;
    next_pop    = 1'b0;
    next_xreg   = 1'b0;
    if (rng(op, `CIDEC_ADDSUB_FIRST, `CIDEC_ADDSUB_LAST)) begin
      d          = op - `CIDEC_ADDSUB_FIRST;
      next_byte  = d[0];
      next_carry = d[1];
      next_sub   = d[2];
    end else if (rng(op, `CIDEC_MULTIPLY_FIRST, `CIDEC_MULTIPLY_LAST)) begin
      d           = op - `CIDEC_MULTIPLY_FIRST;
      next_signed = !d[0];
    end else if (rng(op, `CIDEC_DIVIDE_FIRST, `CIDEC_DIVIDE_LAST)) begin
      d           = op - `CIDEC_DIVIDE_FIRST;
      next_signed = !d[0];
      next_long   = d[1];
    end else if (rng(op, `CIDEC_CPLNEG_FIRST, `CIDEC_CPLNEG_LAST)) begin
      d         = op - `CIDEC_CPLNEG_FIRST;
      next_byte = d[0];
      next_sub  = d[1];
    end else if (rng(op, `CIDEC_LOGIC_FIRST, `CIDEC_LOGIC_LAST)) begin
      d         = op - `CIDEC_LOGIC_FIRST;
      next_byte = d[0];
    end else if (rng(op, `CIDEC_BITSC_FIRST, `CIDEC_BITSC_LAST)) begin
      d         = op - `CIDEC_BITSC_FIRST;
      next_bwr  = 1'b1;
      next_bval = d[0];
    end else if (rng(op, `CIDEC_BITPAIR_FIRST, `CIDEC_BITPAIR_LAST)) begin
      d = op - `CIDEC_BITPAIR_FIRST;
    end else if (rng(op, `CIDEC_BITFIELD_FIRST, `CIDEC_BITFIELD_LAST)) begin
      d         = op - `CIDEC_BITFIELD_FIRST;
      next_high = !d[0];
    end else if (rng(op, `CIDEC_COMPARE_FIRST, `CIDEC_COMPARE_LAST)) begin
      d         = op - `CIDEC_COMPARE_FIRST;
      next_byte = (d == 7'h01);
      next_sub  = 1'b1;
      if (d >= 7'h02) begin
        next_step = d[0] ? 2'h2 : 2'h1;
        next_down = (d < 7'h04);
      end
    end else if (op == `CIDEC_NORMALIZE_COUNT_OP) begin
      d = 7'h00;
    end else if (rng(op, `CIDEC_SHIFT_FIRST, `CIDEC_SHIFT_LAST)) begin
      d           = op - `CIDEC_SHIFT_FIRST;
      next_signed = (d == 7'h04);
    end else if (rng(op, `CIDEC_MOVE_FIRST, `CIDEC_MOVE_LAST)) begin
      d           = op - `CIDEC_MOVE_FIRST;
      next_byte   = (d != 7'h00);
      next_signed = (d == 7'h02);
    end else if (rng(op, `CIDEC_BITJUMP_FIRST, `CIDEC_BITJUMP_LAST)) begin
      d         = op - `CIDEC_BITJUMP_FIRST;
      next_cond = 1'b1;
      next_bwr  = d[0];
      next_bval = d[1];
    end else if (rng(op, `CIDEC_JUMP_FIRST, `CIDEC_JUMP_LAST)) begin
      d         = op - `CIDEC_JUMP_FIRST;
      next_far  = (d == 7'h03) || (d == 7'h07);
      next_call = (d >= 7'h04);
      next_push = (d == 7'h08);
      next_cond = !next_far && !next_push;
    end else if (op == `CIDEC_CONTEXT_SWITCH_OP) begin
      next_push = 1'b1;
    end else if (rng(op, `CIDEC_PUSHPOP_FIRST, `CIDEC_PUSHPOP_LAST)) begin
      d         = op - `CIDEC_PUSHPOP_FIRST;
      next_push = !d[0];
      next_pop  = d[0];
    end else if (op == `CIDEC_TRAP_OP) begin
      next_call = 1'b1;
    end else if (rng(op, `CIDEC_RETURN_FIRST, `CIDEC_RETURN_LAST)) begin
      d        = op - `CIDEC_RETURN_FIRST;
      next_pop = (d == 7'h01);
      next_far = (d == 7'h02);
    end else if (rng(op, `CIDEC_SYSCTL_FIRST, `CIDEC_SYSCTL_LAST)) begin
      d = op - `CIDEC_SYSCTL_FIRST;
    end else if (rng(op, `CIDEC_SHORTSYS_FIRST, `CIDEC_SHORTSYS_LAST)) begin
      d = op - `CIDEC_SHORTSYS_FIRST;
    end else if (rng(op, `CIDEC_SHORTPFX_FIRST, `CIDEC_SHORTPFX_LAST)) begin
      d         = op - `CIDEC_SHORTPFX_FIRST;
      next_xreg = d[0];
    end else if (rng(op, `CIDEC_LONGPFX_FIRST, `CIDEC_LONGPFX_LAST)) begin
      d         = op - `CIDEC_LONGPFX_FIRST;
      next_xreg = d[0];
      next_far  = d[1];
    end else if (rng(op, `CIDEC_COPROC_FIRST, `CIDEC_COPROC_LAST)) begin
      d = op - `CIDEC_COPROC_FIRST;
    end
  end

  // Sequencer: opcode, lookup, trailing bytes, hand-off
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      state         <= S_IDLE;
      op            <= 7'h00;
      op_lsb        <= 1'b0;
      idx           <= 2'h0;
      last_idx      <= 2'h0;
      fetch_adv_out <= 1'b0;
    end else begin
      fetch_adv_out <= (state == S_LOOK);
      case (state)
        S_IDLE: begin
          if (take) begin
            op     <= code_byte_in[7:1];
            op_lsb <= code_byte_in[0];
            state  <= S_LOOK;
          end
        end
        S_LOOK: begin
          idx      <= 2'h0;
          last_idx <= next_len4 ? 2'h2 : 2'h0;
          state    <= S_COLL;
        end
        S_COLL: begin
          if (take) begin
            idx <= idx + 2'h1;
            if (idx == last_idx) begin
              state <= S_OUT;
            end
          end
        end
        S_OUT: begin
          if (exec_ready_in) begin
            state <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // Decoded fields, captured once the lookup entry is ready
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      instr_op_out        <= 7'h00;
      instr_class_out     <= 4'h0;
      instr_fn_out        <= 4'h0;
      instr_len4_out      <= 1'b0;
      instr_illegal_out   <= 1'b0;
      instr_no_action_out <= 1'b0;
      instr_byte_out      <= 1'b0;
      instr_carry_out     <= 1'b0;
      instr_sub_out       <= 1'b0;
      instr_signed_out    <= 1'b0;
      instr_long_out      <= 1'b0;
      instr_high_out      <= 1'b0;
      instr_step_out      <= 2'h0;
      instr_step_down_out <= 1'b0;
      instr_cond_out      <= 1'b0;
      instr_bit_write_out <= 1'b0;
      instr_bit_value_out <= 1'b0;
      instr_far_out       <= 1'b0;
      instr_call_out      <= 1'b0;
      instr_push_out      <= 1'b0;
      instr_pop_out       <= 1'b0;
      instr_ext_reg_out   <= 1'b0;
      fetch_len4_out      <= 1'b0;
    end else if (state == S_LOOK) begin
      instr_op_out        <= op;
      instr_class_out     <= next_ill ? 4'h0 : rom_data[3:0];
      instr_fn_out        <= next_ill ? 4'h0 : d[3:0];
      instr_len4_out      <= next_len4;
      fetch_len4_out      <= next_len4;
      instr_illegal_out   <= next_ill;
      instr_no_action_out <= next_noact;
      instr_byte_out      <= next_byte && !next_ill;
      instr_carry_out     <= next_carry && !next_ill;
      instr_sub_out       <= next_sub && !next_ill;
      instr_signed_out    <= next_signed && !next_ill;
      instr_long_out      <= next_long && !next_ill;
      instr_high_out      <= next_high && !next_ill;
      instr_step_out      <= next_ill ? 2'h0 : next_step;
      instr_step_down_out <= next_down && !next_ill;
      instr_cond_out      <= next_cond && !next_ill;
      instr_bit_write_out <= next_bwr && !next_ill;
      instr_bit_value_out <= next_bval && !next_ill;
      instr_far_out       <= next_far && !next_ill;
      instr_call_out      <= next_call && !next_ill;
      instr_push_out      <= next_push && !next_ill;
      instr_pop_out       <= next_pop && !next_ill;
      instr_ext_reg_out   <= next_xreg && !next_ill;
    end
  end

endmodule

// ==== test/cidec_properties.sv ====
// Checker of decoder hand-off and instruction length rules
`timescale 1ns/10ps
`include "cidec_map.vh"
module cidec_properties (
  input wire       sys_clk_in,
  input wire       rst_in,
  input wire       code_ready_out,
  input wire       exec_ready_in,
  input wire       instr_valid_out,
  input wire [6:0] instr_op_out,
  input wire [3:0] instr_class_out,
  input wire       instr_len4_out,
  input wire       instr_illegal_out,
  input wire       instr_no_action_out,
  input wire       fetch_adv_out,
  input wire       fetch_len4_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  wire       v = instr_valid_out;
  wire [3:0] k = instr_class_out;
  wire       l = instr_len4_out;
  sequence s_lookup; !code_ready_out && !v; endsequence
  sequence s_pulse; fetch_adv_out ##1 !fetch_adv_out; endsequence
  sequence s_held; v && !exec_ready_in; endsequence
  AST_LOOKUP: assert property (s_lookup |=> s_pulse)
    else $error("length pulse missing after lookup");
  AST_LEN_PAIR: assert property (v |-> l == fetch_len4_out)
    else $error("decoded length differs from fetch length");
  AST_HOLD: assert property (s_held |=> v && $stable(instr_op_out) && $stable(l))
    else $error("decode dropped before hand-off");
  AST_BUSY: assert property (v |-> !code_ready_out)
    else $error("byte accepted while decode pending");
  AST_MULDIV: assert property (v && k == `CIDEC_CLS_MULDIV |-> !l)
    else $error("multiply or divide not 2 bytes");
  AST_SHIFT: assert property (v && k == `CIDEC_CLS_SHIFT |-> !l)
    else $error("shift not 2 bytes");
  AST_RETURN: assert property (v && k == `CIDEC_CLS_RETURN |-> !l)
    else $error("return not 2 bytes");
  AST_COPROC: assert property (v && k == `CIDEC_CLS_COPROC |-> l)
    else $error("coprocessor op not 4 bytes");
  AST_JUMP: assert property (v && k == `CIDEC_CLS_JUMP && instr_op_out != `CIDEC_TRAP_OP
    |-> l)
    else $error("jump or call not 4 bytes");
  AST_POWER_DOWN_OP: assert property (v && instr_op_out == `CIDEC_POWER_DOWN_OP && !instr_illegal_out
    |-> instr_no_action_out && l)
    else $error("power-down not a 4-byte no-action op");
  AST_ILLEGAL: assert property (v && instr_illegal_out |-> k == 4'h0 && !l)
    else $error("illegal op with class or long length");
endmodule
bind cidec_top cidec_properties u_props (.*);

// ==== test/cidec_fetch_model.sv ====
// Fetch path and datapath model: feeds code bytes, takes decodes
`timescale 1ns/10ps
module cidec_fetch_model (
  input  wire        sys_clk_in,
  input  wire        code_ready_out,
  input  wire        fetch_adv_out,
  input  wire        fetch_len4_out,
  output logic [7:0] code_byte_in,
  output logic       code_valid_in,
  output logic       exec_ready_in
);
  logic adv_seen;
  logic len_seen;
  initial begin
    code_byte_in = 8'h00;
    code_valid_in = 1'b0;
    exec_ready_in = 1'b0;
  end
  // Offer a byte at a falling edge and hold it until taken
  task put(input logic [7:0] b);
    logic r;
    int i;
    begin
      code_byte_in = b;
      code_valid_in = 1'b1;
      r = 1'b0;
      for (i = 0; i < 50 && !r; i++) begin
        r = (code_ready_out === 1'b1);
        @(posedge sys_clk_in);
        @(negedge sys_clk_in);
      end
    end
  endtask
  // Length pulse is caught at every rising edge, whatever the gap between bytes
  always @(posedge sys_clk_in) begin
    if (fetch_adv_out === 1'b1) begin
      adv_seen <= 1'b1;
      len_seen <= fetch_len4_out;
    end
  end
  // Released line shows the inverse of the last byte
  task idle(input int g);
    if (g > 0) begin
      code_valid_in = 1'b0;
      code_byte_in = ~code_byte_in;
      repeat (g) @(negedge sys_clk_in);
    end
  endtask
  task send(input logic [7:0] opc, input logic [23:0] opnd, input int gap);
    int i;
    begin
      adv_seen = 1'b0;
      len_seen = 1'b0;
      put(opc);
      idle(gap);
      i = 0;
      do begin
        put(opnd[8*i+:8]);
        i++;
        idle(gap);
      end while (i < (len_seen ? 3 : 1));
      code_valid_in = 1'b0;
    end
  endtask
  task take(input int stall);
    repeat (stall) @(negedge sys_clk_in);
    exec_ready_in = 1'b1;
    @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    exec_ready_in = 1'b0;
  endtask
endmodule

// ==== test/test_cpu_instruction_decode_classes.sv ====
// Self-checking bench of the instruction decoder
`timescale 1ns/10ps
module test_cpu_instruction_decode_classes;
  logic        sys_clk_in;
  logic        rst_in;
  wire  [7:0]  code_byte_in;
  wire         code_valid_in, exec_ready_in, code_ready_out, instr_valid_out;
  wire         instr_len4_out, instr_illegal_out, instr_no_action_out;
  wire         fetch_adv_out, fetch_len4_out;
  wire  [6:0]  instr_op_out;
  wire  [3:0]  instr_class_out;
  wire  [23:0] instr_operand_out;
  wire  [3:0]  instr_fn_out;
  wire  [1:0]  instr_step_out;
  wire         instr_byte_out, instr_carry_out, instr_sub_out, instr_signed_out, instr_long_out;
  wire         instr_high_out, instr_step_down_out, instr_cond_out, instr_bit_write_out;
  wire         instr_bit_value_out, instr_far_out, instr_call_out, instr_push_out, instr_pop_out;
  wire         instr_ext_reg_out;
  int          mismatches, compares, seed;
  logic [7:0]  corner [44];
  cidec_top uut (.*);
  cidec_fetch_model fm (.*);
  // Expected {illegal, len4, class}; class 4'hF means not predicted
  function automatic logic [5:0] expect_of(input logic [7:0] c);
    logic [6:0] o;
    logic       v4, f4, ill;
    logic [3:0] k;
    begin
      o = c[7:1];
      v4 = o <= 7'h07 || (o >= 7'h12 && o <= 7'h17) || (o >= 7'h22 && o <= 7'h27)
        || (o >= 7'h2E && o <= 7'h31) || (o >= 7'h52 && o <= 7'h55);
      f4 = (o >= 7'h1A && o <= 7'h21) || (o >= 7'h32 && o <= 7'h3F)
        || (o >= 7'h47 && o <= 7'h4D) || (o >= 7'h56 && o <= 7'h66);
      ill = o > 7'h66 || (c[0] && !v4);
      k = o <= 7'h07 ? 4'h0 : o <= 7'h0D ? 4'h1 : o <= 7'h11 ? 4'hF : o <= 7'h17 ? 4'h2
        : o <= 7'h21 ? 4'h3 : o <= 7'h28 ? 4'hF : o <= 7'h2D ? 4'h4 : o <= 7'h31 ? 4'h5
        : o <= 7'h35 ? 4'hF : o <= 7'h3E ? 4'h6 : o <= 7'h3F ? 4'hF : o <= 7'h41 ? 4'h7
        : o <= 7'h42 ? 4'hF : o <= 7'h46 ? 4'h8 : o <= 7'h47 ? 4'hF : o <= 7'h4F ? 4'h9
        : o <= 7'h55 ? 4'hA : 4'hB;
      return {ill, !ill && (f4 || (v4 && c[0])), ill ? 4'h0 : k};
    end
  endfunction
  // Expected {byte,carry,sub,signed,long,high,step,down,cond,bwr,bval,far,call,push,pop,xreg}
  function automatic logic [16:0] attr_of(input logic [6:0] o);
    logic       b, c, s, g, l, h, dn, cd, bw, bv, f, cl, pu, po, x;
    logic [1:0] st;
    begin
      b = (o <= 7'h07 || (o >= 7'h12 && o <= 7'h17)) && o[0] || o == 7'h0F || o == 7'h11
        || o == 7'h23 || (o >= 7'h2F && o <= 7'h31);
      c = o <= 7'h07 && o[1];
      s = o <= 7'h07 && o[2] || o == 7'h10 || o == 7'h11 || (o >= 7'h22 && o <= 7'h27);
      g = o == 7'h08 || o == 7'h0A || o == 7'h0C || o == 7'h2D || o == 7'h30;
      l = o == 7'h0C || o == 7'h0D;
      h = o == 7'h20;
      st = (o == 7'h24 || o == 7'h26) ? 2'h1 : (o == 7'h25 || o == 7'h27) ? 2'h2 : 2'h0;
      dn = o == 7'h24 || o == 7'h25;
      cd = (o >= 7'h32 && o <= 7'h38) || o == 7'h3A || o == 7'h3B || o == 7'h3C;
      bw = o == 7'h18 || o == 7'h19 || o == 7'h33 || o == 7'h35;
      bv = o == 7'h19 || o == 7'h34 || o == 7'h35;
      f = o == 7'h39 || o == 7'h3D || o == 7'h45 || o == 7'h54 || o == 7'h55;
      cl = (o >= 7'h3A && o <= 7'h3E) || o == 7'h42;
      pu = o == 7'h3E || o == 7'h3F || o == 7'h40;
      po = o == 7'h41 || o == 7'h44;
      x = o == 7'h51 || o == 7'h53 || o == 7'h55;
      return {b, c, s, g, l, h, st, dn, cd, bw, bv, f, cl, pu, po, x};
    end
  endfunction
  task chk(input logic [23:0] got, input logic [23:0] want);
    compares++;
    if (got !== want) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task results;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task run(input logic [7:0] c, input int gap, input int stall);
    logic [5:0]  e;
    logic [23:0] d;
    logic [6:0]  o;
    int          w;
    begin
      d = 24'($random(seed));
      e = expect_of(c);
      o = c[7:1];
      fm.send(c, d, gap);
      for (w = 0; w < 20 && instr_valid_out !== 1'b1; w++) @(negedge sys_clk_in);
      chk(24'(instr_valid_out), 24'h1);
      chk(24'(fm.adv_seen), 24'h1);
      chk(24'(fm.len_seen), 24'(e[4]));
      chk(24'(instr_op_out), 24'(o));
      chk(24'(instr_illegal_out), 24'(e[5]));
      chk(24'(instr_len4_out), 24'(e[4]));
      if (e[3:0] != 4'hF) chk(24'(instr_class_out), 24'(e[3:0]));
      chk(instr_operand_out, e[4] ? d : {16'h0000, d[7:0]});
      chk(24'(instr_no_action_out), 24'(!e[5] && (o == 7'h47 || o == 7'h4F || o == 7'h66)));
      chk(24'({instr_byte_out, instr_carry_out, instr_sub_out, instr_signed_out,
        instr_long_out, instr_high_out, instr_step_out, instr_step_down_out, instr_cond_out,
        instr_bit_write_out, instr_bit_value_out, instr_far_out, instr_call_out, instr_push_out,
        instr_pop_out, instr_ext_reg_out}), 24'(e[5] ? 17'h0 : attr_of(o)));
      if (e[5] || o <= 7'h07) chk(24'(instr_fn_out), 24'(e[5] ? 4'h0 : o[3:0]));
      fm.take(stall);
    end
  endtask
  initial begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    #240000;
    mismatches++;
    results;
  end
  initial begin
    seed = 80;
    mismatches = 0;
    compares = 0;
    rst_in = 1'b1;
    corner = '{8'h00, 8'h0F,
      8'h10, 8'h12, 8'h14, 8'h1A,
      8'h1C, 8'h22, 8'h1D,
      8'h24, 8'h2F,
      8'h30, 8'h32, 8'h34, 8'h3E,
      8'h40, 8'h42, 8'h44, 8'h4F,
      8'h50, 8'h52, 8'h5A,
      8'h5C, 8'h63, 8'h64, 8'h6A,
      8'h6C, 8'h7C, 8'h7E, 8'h80, 8'h82,
      8'h84, 8'h86, 8'h8C,
      8'h8E, 8'h8F,
      8'hA0, 8'hA2, 8'hA4, 8'hAB,
      8'hAC, 8'hCC, 8'hCE, 8'hFF};
    repeat (2) @(negedge sys_clk_in);
    rst_in = 1'b0;
    foreach (corner[i]) run(corner[i], i % 3, (i % 4 == 0) ? 3 : 0);
    repeat (200) run(8'($random(seed)), $random(seed) & 3, $random(seed) & 3);
    results;
  end
endmodule
